// file: hw/mfre_map.vh
`ifndef MFRE_MAP_VH
`define MFRE_MAP_VH

// ****************************************************************
// Opcodes of the multi-pin random-access reads
// ****************************************************************
`define MFRE_OPC_DUAL_IO     8'hBB
`define MFRE_OPC_DUAL_IO_4B  8'hBC
`define MFRE_OPC_QUAD_IO     8'hEB
`define MFRE_OPC_QUAD_IO_4B  8'hEC

// ****************************************************************
// Field positions and values
// ****************************************************************
`define MFRE_BYPASS_HI       5
`define MFRE_BYPASS_LO       4
`define MFRE_BYPASS_KEEP     2'h2
`define MFRE_WRAP_EN_BIT     0
`define MFRE_WRAP_LEN_HI     2
`define MFRE_WRAP_LEN_LO     1
`define MFRE_WRAP_BASE       8'h08

// ****************************************************************
// Phase lengths in bits or link clocks
// ****************************************************************
`define MFRE_OPC_BITS        6'h08
`define MFRE_MODE_BITS       6'h08
`define MFRE_ADDR_BITS_3B    6'h18
`define MFRE_ADDR_BITS_4B    6'h20
`define MFRE_DUMMY_DUAL      4'h0
`define MFRE_DUMMY_QUAD_SPI  4'h4
`define MFRE_DUMMY_QPI_BASE  4'h2

// ****************************************************************
// Reset values
// ****************************************************************
`define MFRE_RST_IO_OE_N     4'hF
`define MFRE_RST_BYPASS      1'b0

`endif

// file: hw/mfre_addr_step.v
`timescale 1ns/1ps
`include "mfre_map.vh"

// ****************************************************************
// Next read address, with optional section wrap in a page
// ****************************************************************
module mfre_addr_step #(
   parameter AW = 32
) (
   // Current address
   input  wire [AW-1:0] cur_addr,
   // Wrap control
   input  wire          wrap_on,
   input  wire [1:0]    wrap_len,
   // Result
   output wire [AW-1:0] next_addr
);

   wire [7:0]    sect_size;
   wire [AW-1:0] sect_mask;
   wire [AW-1:0] plus_one;

   // Section of 8, 16, 32 or 64 bytes, never beyond the page
   assign sect_size = `MFRE_WRAP_BASE << wrap_len;
   assign sect_mask = {{(AW-8){1'b0}}, sect_size - 8'h01};
   assign plus_one  = cur_addr + {{(AW-1){1'b0}}, 1'b1};

   // Wrap keeps the upper bits and rolls only inside the section
   assign next_addr = wrap_on ?
                      ((cur_addr & ~sect_mask) | (plus_one & sect_mask)) :
                      plus_one;

endmodule // mfre_addr_step

// file: hw/mfre_read_engine.v
// What this block does
// - BBh takes address and data on two pins
// - Mode byte follows address; only bits 5:4 matter
// - Bypass bits 10 skip next two-pin opcode
// - Other bypass values demand opcode next time
// - BCh always 32-bit address, else like BBh
// - BCh accepted only in single-pin command mode
// - Address is 32 bits in 4-byte mode
// - EBh moves four bits per clock, four dummies
// - Four-pin read needs quad enable bit set
// - Bypass bits 10 skip next four-pin opcode
// - Wrap restarts at section start until deselect
// - Wrap enable bit and length bits select section
// - EBh also accepted in four-pin command mode
// - Four-pin mode dummies follow read parameter field
// - No wrap in four-pin command mode
// - ECh always 32-bit address, else like EBh
// - ECh accepted only in single-pin command mode
// - Wrap off when enable bit is one
// - Address advances after each output byte
// - Reads ignored while device is busy
`timescale 1ns/1ps
`include "mfre_map.vh"

module mfre_read_engine #(
   parameter AW = 32
) (
   // Clock and reset
   input  wire          clk,
   input  wire          nrst,
   // Serial link pins
   input  wire          cs_n,
   input  wire          sclk,
   input  wire [3:0]    io_in,
   output reg  [3:0]    io_out,
   output reg  [3:0]    io_oe_n,
   // Configuration levels
   input  wire          four_byte_mode,
   input  wire          four_pin_command_mode,
   input  wire          quad_io_enable_bit,
   input  wire          busy,
   input  wire [2:0]    wrap_setting_bits,
   input  wire [1:0]    read_param_bits,
   // Array read port
   output reg  [AW-1:0] mem_addr,
   output reg           mem_req,
   input  wire [7:0]    mem_rdata,
   // Status
   output reg           bypass_active,
   output reg           read_active
);

   // ****************************************************************
   // States
   // ****************************************************************
   localparam [5:0] ST_IDLE  = 6'h01;
   localparam [5:0] ST_OPC   = 6'h02;
   localparam [5:0] ST_ADDR  = 6'h04;
   localparam [5:0] ST_MODE  = 6'h08;
   localparam [5:0] ST_DUMMY = 6'h10;
   localparam [5:0] ST_DATA  = 6'h20;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   reg  [5:0]    sync1_q;
   reg  [5:0]    sync2_q;
   reg           sclk_prev_q;
   reg           cs_prev_q;
   reg  [5:0]    state_q;
   reg  [5:0]    cnt_q;
   reg  [7:0]    opc_q;
   reg  [AW-1:0] addr_q;
   reg  [7:0]    mode_q;
   reg           quad_q;
   reg           wide_q;
   reg           byp_quad_q;
   reg           byp_wide_q;
   reg           pend_q;
   reg           mode_done_q;
   reg  [7:0]    sh_q;
   reg  [1:0]    slice_q;
   reg           load_q;
   reg  [3:0]    dummy_tgt;
   reg  [2:0]    step;
   reg           dec_ok;
   reg           dec_quad;
   reg           dec_wide;
   wire          cs_s;
   wire          sclk_s;
   wire [3:0]    io_s;
   wire          rise;
   wire          fall;
   wire          cs_fall;
   wire          cs_rise;
   wire [5:0]    cnt_nx;
   wire [5:0]    addr_bits;
   wire [7:0]    opc_nx;
   wire [7:0]    mode_nx;
   wire [AW-1:0] opc_wide;
   wire [AW-1:0] mode_wide;
   wire [AW-1:0] addr_nx;
   wire [AW-1:0] next_addr;
   wire          wrap_on;
   wire          last_slice;

   // Shift lane bits in, highest lane carries the higher bit
   function [AW-1:0] shin;
      input [AW-1:0] v;
      input [3:0]    d;
      input [2:0]    n;
      begin
         case (n)
            3'h1:    shin = {v[AW-2:0], d[0]};
            3'h2:    shin = {v[AW-3:0], d[1:0]};
            default: shin = {v[AW-5:0], d};
         endcase
      end
   endfunction

   // ****************************************************************
   // Pin synchronisers and edge finding
   // ****************************************************************
   // Two flops on every pin; the link clock is far slower than clk
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q     <= 6'h3F;
         sync2_q     <= 6'h3F;
         sclk_prev_q <= 1'b1;
         cs_prev_q   <= 1'b1;
      end else begin
         sync1_q     <= {cs_n, sclk, io_in};
         sync2_q     <= sync1_q;
         sclk_prev_q <= sync2_q[4];
         cs_prev_q   <= sync2_q[5];
      end
   end

   assign cs_s    = sync2_q[5];
   assign sclk_s  = sync2_q[4];
   assign io_s    = sync2_q[3:0];
   assign rise    = sclk_s & ~sclk_prev_q & ~cs_s;
   assign fall    = ~sclk_s & sclk_prev_q & ~cs_s;
   assign cs_fall = ~cs_s & cs_prev_q;
   assign cs_rise = cs_s & ~cs_prev_q;

   // ****************************************************************
   // Phase widths and opcode decode
   // ****************************************************************
   // Lanes per link clock in the current phase
   always @* begin
      if (state_q == ST_OPC)
         step = four_pin_command_mode ? 3'h4 : 3'h1;
      else
         step = quad_q ? 3'h4 : 3'h2;
   end

   // Dummy clocks ahead of data
   always @* begin
      if (!quad_q)
         dummy_tgt = `MFRE_DUMMY_DUAL;
      else if (four_pin_command_mode)
         dummy_tgt = `MFRE_DUMMY_QPI_BASE +
                     {1'b0, read_param_bits, 1'b0};
      else
         dummy_tgt = `MFRE_DUMMY_QUAD_SPI;
   end

   // Only the four multi-pin reads are taken, never while busy
   always @* begin
      dec_ok   = 1'b0;
      dec_quad = 1'b0;
      dec_wide = four_byte_mode;
      case (opc_nx)
         `MFRE_OPC_DUAL_IO: begin
            dec_ok = ~four_pin_command_mode;
         end
         `MFRE_OPC_DUAL_IO_4B: begin
            dec_ok   = ~four_pin_command_mode;
            dec_wide = 1'b1;
         end
         `MFRE_OPC_QUAD_IO: begin
            dec_ok   = quad_io_enable_bit;
            dec_quad = 1'b1;
         end
         `MFRE_OPC_QUAD_IO_4B: begin
            dec_ok   = quad_io_enable_bit &
                       ~four_pin_command_mode;
            dec_quad = 1'b1;
            dec_wide = 1'b1;
         end
         default: begin
            dec_ok = 1'b0;
         end
      endcase
      if (busy)
         dec_ok = 1'b0;
   end

   assign cnt_nx    = cnt_q + {3'h0, step};
   assign addr_bits = wide_q ? `MFRE_ADDR_BITS_4B : `MFRE_ADDR_BITS_3B;
   // Shifter is address wide; only the low byte is kept
   assign opc_wide  = shin({{(AW-8){1'b0}}, opc_q}, io_s, step);
   assign mode_wide = shin({{(AW-8){1'b0}}, mode_q}, io_s, step);
   assign opc_nx    = opc_wide[7:0];
   assign mode_nx   = mode_wide[7:0];
   assign addr_nx   = shin(addr_q, io_s, step);
   assign last_slice = quad_q ? (slice_q == 2'h1) : (slice_q == 2'h3);

   // Wrap only for four-pin reads in single-pin command mode
   assign wrap_on = quad_q & ~four_pin_command_mode &
                    ~wrap_setting_bits[`MFRE_WRAP_EN_BIT];

   // ****************************************************************
   // Address advance
   // ****************************************************************
   mfre_addr_step #(
      .AW        (AW)
   ) u_step (
      .cur_addr  (addr_q),
      .wrap_on   (wrap_on),
      .wrap_len  (wrap_setting_bits[`MFRE_WRAP_LEN_HI:`MFRE_WRAP_LEN_LO]),
      .next_addr (next_addr)
   );

   // ****************************************************************
   // Transaction sequencer
   // ****************************************************************
   // Input sampled on link rising edges, data driven on falling ones
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q       <= ST_IDLE;
         cnt_q         <= 6'h00;
         opc_q         <= 8'h00;
         addr_q        <= {AW{1'b0}};
         mode_q        <= 8'h00;
         quad_q        <= 1'b0;
         wide_q        <= 1'b0;
         byp_quad_q    <= 1'b0;
         byp_wide_q    <= 1'b0;
         pend_q        <= 1'b0;
         mode_done_q   <= 1'b0;
         bypass_active <= `MFRE_RST_BYPASS;
         sh_q          <= 8'h00;
         slice_q       <= 2'h0;
         load_q        <= 1'b0;
         io_out        <= 4'h0;
         io_oe_n       <= `MFRE_RST_IO_OE_N;
         mem_addr      <= {AW{1'b0}};
         mem_req       <= 1'b0;
         read_active   <= 1'b0;
      end else begin
         mem_req <= 1'b0;
         load_q  <= mem_req;
         if (load_q)
            sh_q <= mem_rdata;
         if (cs_rise) begin
            // Bypass decided only by a mode byte fully received
            if (state_q != ST_IDLE)
               bypass_active <= mode_done_q & pend_q;
            state_q     <= ST_IDLE;
            io_oe_n     <= `MFRE_RST_IO_OE_N;
            read_active <= 1'b0;
            mode_done_q <= 1'b0;
         end else if (cs_fall) begin
            cnt_q   <= 6'h00;
            opc_q   <= 8'h00;
            addr_q  <= {AW{1'b0}};
            slice_q <= 2'h0;
            if (bypass_active & ~busy) begin
               // No opcode: address starts at the first clock
               state_q     <= ST_ADDR;
               quad_q      <= byp_quad_q;
               wide_q      <= byp_wide_q;
               read_active <= 1'b1;
            end else if (bypass_active) begin
               state_q <= ST_IDLE;
            end else begin
               state_q <= ST_OPC;
            end
         end else if (rise) begin
            case (state_q)
               ST_OPC: begin
                  opc_q <= opc_nx;
                  cnt_q <= cnt_nx;
                  if (cnt_nx == `MFRE_OPC_BITS) begin
                     cnt_q       <= 6'h00;
                     quad_q      <= dec_quad;
                     wide_q      <= dec_wide;
                     byp_quad_q  <= dec_quad;
                     byp_wide_q  <= dec_wide;
                     read_active <= dec_ok;
                     state_q     <= dec_ok ? ST_ADDR : ST_IDLE;
                  end
               end
               ST_ADDR: begin
                  addr_q <= addr_nx;
                  cnt_q  <= cnt_nx;
                  if (cnt_nx == addr_bits) begin
                     cnt_q   <= 6'h00;
                     state_q <= ST_MODE;
                  end
               end
               ST_MODE: begin
                  mode_q <= mode_nx;
                  cnt_q  <= cnt_nx;
                  if (cnt_nx == `MFRE_MODE_BITS) begin
                     cnt_q       <= 6'h00;
                     mode_done_q <= 1'b1;
                     // Lower nibble of the mode byte is ignored
                     pend_q <= (mode_nx[`MFRE_BYPASS_HI:`MFRE_BYPASS_LO]
                                == `MFRE_BYPASS_KEEP);
                     if (dummy_tgt == 4'h0) begin
                        state_q  <= ST_DATA;
                        mem_addr <= addr_q;
                        mem_req  <= 1'b1;
                     end else begin
                        state_q <= ST_DUMMY;
                     end
                  end
               end
               ST_DUMMY: begin
                  cnt_q <= cnt_q + 6'h01;
                  if (cnt_q + 6'h01 == {2'h0, dummy_tgt}) begin
                     state_q  <= ST_DATA;
                     mem_addr <= addr_q;
                     mem_req  <= 1'b1;
                  end
               end
               ST_DATA: begin
                  state_q <= ST_DATA;
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end else if (fall && state_q == ST_DATA) begin
            // Host has let go of the pins by this edge
            if (quad_q) begin
               io_out  <= sh_q[7:4];
               io_oe_n <= 4'h0;
               sh_q    <= {sh_q[3:0], 4'h0};
            end else begin
               io_out  <= {2'h0, sh_q[7:6]};
               io_oe_n <= 4'hC;
               sh_q    <= {sh_q[5:0], 2'h0};
            end
            slice_q <= slice_q + 2'h1;
            if (last_slice) begin
               // Fetch ahead; the next byte lands long before its edge
               slice_q  <= 2'h0;
               addr_q   <= next_addr;
               mem_addr <= next_addr;
               mem_req  <= 1'b1;
            end
         end
      end
   end

endmodule // mfre_read_engine

// file: sim/mfre_read_engine_assertions.sv
`timescale 1ns/1ps
// ******************************
// Port checks of the read engine
// ******************************
module mfre_read_engine_assertions #(
   parameter AW = 32
) (
   // Clock and reset
   input wire logic          clk,
   input wire logic          nrst,
   // Link
   input wire logic          cs_n,
   input wire logic          sclk,
   input wire logic [3:0]    io_out,
   input wire logic [3:0]    io_oe_n,
   // Configuration
   input wire logic          four_pin_command_mode,
   input wire logic          quad_io_enable_bit,
   input wire logic          busy,
   input wire logic [2:0]    wrap_setting_bits,
   // Array port and status
   input wire logic [AW-1:0] mem_addr,
   input wire logic          mem_req,
   input wire logic          bypass_active,
   input wire logic          read_active
);
   logic [AW-1:0] prev_q;
   logic          have_q;
   logic [AW-1:0] msk;
   logic [AW-1:0] nxt;

   // Last fetch address, forgotten between frames
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_q <= '0;
         have_q <= 1'b0;
      end else if (cs_n) begin
         have_q <= 1'b0;
      end else if (mem_req) begin
         prev_q <= mem_addr;
         have_q <= 1'b1;
      end
   end

   // Section mask and successor inside the section
   assign msk = ~({AW{1'b1}} << ({1'b0, wrap_setting_bits[2:1]} + 3'h3));
   assign nxt = (prev_q & ~msk) | ((prev_q + 1'b1) & msk);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // Steps: frame gone quiet, then a fetch that follows another
   sequence s_deselected;
      cs_n [*6];
   endsequence
   sequence s_next_fetch;
      mem_req && have_q;
   endsequence

   chk_idle_release:
      assert property (s_deselected |-> io_oe_n == 4'hF)
      else $error("link pins driven while deselected");
   chk_pin_groups:
      assert property (io_oe_n inside {4'hF, 4'hC, 4'h0})
      else $error("unexpected output enable pattern");
   chk_busy_block:
      assert property (busy && !read_active |=> !read_active)
      else $error("read started while busy");
   chk_quad_gate:
      assert property (!quad_io_enable_bit |-> io_oe_n[3:2] == 2'b11)
      else $error("upper pins driven without quad enable");
   chk_fetch_gap:
      assert property (mem_req |=> !mem_req [*7])
      else $error("fetches too close together");
   chk_step_linear:
      assert property (s_next_fetch ##0 (wrap_setting_bits[0] ||
         four_pin_command_mode || io_oe_n != 4'h0) |-> mem_addr == prev_q + 1'b1)
      else $error("fetch address did not advance by one");
   chk_step_wrap:
      assert property (s_next_fetch ##0 (!wrap_setting_bits[0] &&
         !four_pin_command_mode && io_oe_n == 4'h0) |-> mem_addr == nxt)
      else $error("fetch address left its section");
   chk_reset_clear:
      assert property ($rose(nrst) |-> !bypass_active)
      else $error("bypass set after reset");
   chk_bypass_hold:
      assert property ($changed(bypass_active) |-> cs_n)
      else $error("bypass changed inside a frame");
   chk_out_on_fall:
      assert property ($changed(io_out) && !cs_n |-> !sclk)
      else $error("output changed outside the low phase");
endmodule // mfre_read_engine_assertions

bind mfre_read_engine mfre_read_engine_assertions #(.AW(AW)) u_chk (
   .clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk),
   .io_out(io_out), .io_oe_n(io_oe_n),
   .four_pin_command_mode(four_pin_command_mode),
   .quad_io_enable_bit(quad_io_enable_bit), .busy(busy),
   .wrap_setting_bits(wrap_setting_bits), .mem_addr(mem_addr),
   .mem_req(mem_req), .bypass_active(bypass_active),
   .read_active(read_active)
);

// file: sim/mfre_host_model.sv
`timescale 1ns/1ps
// ********************
// Host side of the link
// ********************
module mfre_host_model (
   // Clock
   input  wire logic       clk,
   // Link pins towards the device
   output logic            cs_n,
   output logic            sclk,
   output wire logic [3:0] io_in,
   // Device drive
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe_n
);
   logic [3:0] hv = 4'h0;
   logic [3:0] hen = 4'h0;

   // Idle: deselected, clock parked high
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
   end

   // No pull on the lines, so a released line shows the inverse value
   assign io_in = (~io_oe_n & io_out) | (io_oe_n & ~(hen ^ hv));

   task automatic start();
      cs_n <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // n clocks of w bits, MSB first, changed with the falling clock
   task automatic send(input logic [31:0] v, input int n, input int w);
      for (int i = n - 1; i >= 0; i--) begin
         hen  <= 4'((1 << w) - 1);
         hv   <= 4'((v >> (i * w)) & ((1 << w) - 1));
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask

   // Lines freed before the first output fall, sampled mid high phase
   task automatic recv(input int n, input int w, output logic [7:0] r);
      r = 8'h00;
      hen <= 4'h0;
      @(posedge clk);
      for (int i = 0; i < n; i++) begin
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (2) @(posedge clk);
         r = (r << w) | 8'(io_in & 4'((1 << w) - 1));
         repeat (2) @(posedge clk);
      end
   endtask

   task automatic stop();
      cs_n <= 1'b1;
      hen  <= 4'h0;
      repeat (8) @(posedge clk);
   endtask
endmodule // mfre_host_model

// file: sim/mfre_read_engine_tb.sv
`timescale 1ns/1ps
`include "mfre_map.vh"
// ************************
// Bench for the read engine
// ************************
module mfre_read_engine_tb;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        busy = 1'b0;
   logic        four_byte_mode = 1'b0;
   logic        four_pin_command_mode = 1'b0;
   logic        quad_io_enable_bit = 1'b1;
   logic [2:0]  wrap_setting_bits = 3'h1;
   logic [1:0]  read_param_bits = 2'h0;
   logic [7:0]  mem_rdata = 8'h00;
   logic        drove = 1'b0;
   logic        byp = 1'b0;
   logic [31:0] seed = 32'h1B;
   int          cyc = 0;
   int          num_errors = 0;
   int          n_checks = 0;
   wire         cs_n, sclk, mem_req, bypass_active, read_active;
   wire  [3:0]  io_in, io_out, io_oe_n;
   wire  [31:0] mem_addr;

   mfre_read_engine DUT (
      .clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
      .io_out(io_out), .io_oe_n(io_oe_n), .four_byte_mode(four_byte_mode),
      .four_pin_command_mode(four_pin_command_mode),
      .quad_io_enable_bit(quad_io_enable_bit), .busy(busy),
      .wrap_setting_bits(wrap_setting_bits),
      .read_param_bits(read_param_bits), .mem_addr(mem_addr),
      .mem_req(mem_req), .mem_rdata(mem_rdata),
      .bypass_active(bypass_active), .read_active(read_active)
   );
   mfre_host_model host (
      .clk(clk), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
      .io_out(io_out), .io_oe_n(io_oe_n)
   );

   always #25 clk = ~clk;

   // Array answers one cycle after a request, then goes stale
   always @(posedge clk) mem_rdata <= mem_req ? pat(mem_addr) : ~mem_rdata;

   // Any device drive inside a frame
   always @(posedge clk) if (!cs_n && io_oe_n !== 4'hF) drove <= 1'b1;

   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors++;
         stop_test();
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [7:0] pat(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ 8'h5A;
   endfunction

   // Next byte address, wrapping in the configured section if asked
   function automatic logic [31:0] nxt(input logic [31:0] a, input bit wr);
      logic [31:0] m;
      m = (32'h8 << wrap_setting_bits[2:1]) - 32'h1;
      return wr ? (a & ~m) | ((a + 32'h1) & m) : a + 32'h1;
   endfunction

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // One read frame; opcode left out while bypass is expected
   task automatic rd(input logic [7:0] op, input int w, input int ab,
         input logic [31:0] a, input int dum, input int nb, input bit ok,
         input bit keep, input bit wr);
      logic [7:0]  r;
      logic [7:0]  m;
      logic [31:0] t;
      logic [31:0] ea;
      t = rnd();
      m = {t[7:6], keep ? 2'b10 : {t[5], 1'b1}, t[3:0]};
      ea = (ab == 24) ? a & 32'h00FFFFFF : a;
      drove = 1'b0;
      host.start();
      if (!byp)
         host.send({24'h0, op}, four_pin_command_mode ? 2 : 8,
                   four_pin_command_mode ? 4 : 1);
      host.send(a, ab / w, w);
      host.send({24'h0, m}, 8 / w, w);
      host.send(32'h0, dum, w);
      for (int i = 0; i < nb; i++) begin
         host.recv(8 / w, w, r);
         if (ok) check("data", r, pat(ea));
         ea = nxt(ea, wr);
      end
      host.stop();
      if (ok) byp = keep;
      check("drive", drove, ok);
      check("bypass", bypass_active, byp);
   endtask

   initial begin : main
      logic [31:0] a;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      check("oe", io_oe_n, 4'hF);
      check("bypass", bypass_active, 1'b0);
      done("reset");
      rd(`MFRE_OPC_DUAL_IO, 2, 24, rnd(), 0, 2, 1, 1, 0);
      rd(`MFRE_OPC_DUAL_IO, 2, 24, rnd(), 0, 2, 1, 1, 0);
      rd(`MFRE_OPC_DUAL_IO, 2, 24, rnd(), 0, 1, 1, 0, 0);
      rd(`MFRE_OPC_DUAL_IO, 2, 24, rnd(), 0, 1, 1, 1, 0);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      byp = 1'b0;
      check("bypass", bypass_active, 1'b0);
      rd(`MFRE_OPC_DUAL_IO, 2, 24, rnd(), 0, 1, 1, 1, 0);
      host.start();
      host.send(32'hFFFF, 16, 1);
      host.stop();
      byp = 1'b0;
      check("bypass", bypass_active, 1'b0);
      four_byte_mode <= 1'b1;
      rd(`MFRE_OPC_DUAL_IO, 2, 32, rnd(), 0, 2, 1, 0, 0);
      four_byte_mode <= 1'b0;
      rd(`MFRE_OPC_DUAL_IO_4B, 2, 32, rnd(), 0, 2, 1, 0, 0);
      done("dual");
      rd(`MFRE_OPC_QUAD_IO, 4, 24, rnd(), 4, 2, 1, 1, 0);
      rd(`MFRE_OPC_QUAD_IO, 4, 24, rnd(), 4, 2, 1, 0, 0);
      rd(`MFRE_OPC_QUAD_IO, 4, 24, rnd(), 4, 1, 1, 1, 0);
      host.start();
      host.send(32'hFF, 8, 1);
      host.stop();
      byp = 1'b0;
      check("bypass", bypass_active, 1'b0);
      rd(`MFRE_OPC_QUAD_IO_4B, 4, 32, rnd(), 4, 2, 1, 0, 0);
      for (int l = 0; l < 4; l++) begin
         a = (rnd() & 32'h00FFFF00) | ((32'h8 << l) - 32'h2);
         wrap_setting_bits <= {2'(l), 1'b0};
         rd(`MFRE_OPC_QUAD_IO, 4, 24, a, 4, 3, 1, 0, 1);
         wrap_setting_bits <= {2'(l), 1'b1};
         rd(`MFRE_OPC_QUAD_IO, 4, 24, a, 4, 3, 1, 0, 0);
      end
      done("quad");
      four_pin_command_mode <= 1'b1;
      wrap_setting_bits <= 3'h0;
      for (int p = 0; p < 4; p++) begin
         read_param_bits <= 2'(p);
         rd(`MFRE_OPC_QUAD_IO, 4, 24, rnd() | 32'h6, 2 + 2 * p, 3, 1, 0,
            0);
      end
      rd(`MFRE_OPC_DUAL_IO_4B, 4, 32, rnd(), 0, 1, 0, 0, 0);
      rd(`MFRE_OPC_QUAD_IO_4B, 4, 32, rnd(), 0, 1, 0, 0, 0);
      four_pin_command_mode <= 1'b0;
      quad_io_enable_bit <= 1'b0;
      rd(`MFRE_OPC_QUAD_IO, 4, 24, rnd(), 4, 1, 0, 0, 0);
      quad_io_enable_bit <= 1'b1;
      busy <= 1'b1;
      rd(`MFRE_OPC_DUAL_IO, 2, 24, rnd(), 0, 1, 0, 0, 0);
      busy <= 1'b0;
      rd(`MFRE_OPC_DUAL_IO, 2, 24, rnd(), 0, 1, 1, 0, 0);
      done("modes and refusals");
      stop_test();
   end
endmodule // mfre_read_engine_tb
